// ==== dv/cls_ccd_model.sv ====
// behavioural sensor model: counts rows and pixels and answers with tagged samples
`timescale 1ns/1ps
module cls_ccd_model
    import cls_pkg::*;
(
    // clock
    input wire logic clk_i,
    // sensor clock pins
    input wire logic vertical_phase_one_clock_i,
    input wire logic horizontal_last_gate_clock_i,
    // sample to converter input
    output logic [ADC_WIDTH-1:0] adc_data_o
);
    logic v_q = 1'b0;
    logic g_q = 1'b0;
    logic [6:0] vrow = 7'h00;
    logic [6:0] pcnt = 7'h00;
    logic [ADC_WIDTH-1:0] val = 14'h0000;

    // ==========================================================
    // charge movement
    // row moves on fall
    always_ff @(posedge clk_i) begin
        v_q <= vertical_phase_one_clock_i;
        g_q <= horizontal_last_gate_clock_i;
        if (v_q && !vertical_phase_one_clock_i) begin
            vrow <= vrow + 7'h01;
            pcnt <= 7'h00;
        end else if (horizontal_last_gate_clock_i && !g_q) begin
            val <= {vrow, pcnt};
            pcnt <= pcnt + 7'h01;
        end
    end

    // video is not valid while the gate is high, so show the inverse there
    assign adc_data_o = horizontal_last_gate_clock_i ? ~val : val;
endmodule : cls_ccd_model

// ==== dv/tb.sv ====
// self-checking bench for the ccd timing generator
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module tb;
    import cls_pkg::*;
    typedef struct {logic sgl; logic sht; logic dmp; logic [23:0] integ; logic [15:0] lines;
        logic stall;} cls_row_type;
    cls_row_type rows[3];
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic start_i = 1'b0, mode_single_i = 1'b0, shutter_en_i = 1'b0, dump_en_i = 1'b0;
    logic [23:0] integ_cycles_i = 24'h000000;
    logic [15:0] lines_i = 16'h0001;
    logic busy_o, frame_done_o, v_o, g_o, s_o, d_o, pix_valid_o, pix_ready_i = 1'b1, clr = 1'b1;
    logic [ADC_WIDTH-1:0] adc, pix_data_o, exp_data;
    logic v_q, g_q, s_q, d_q, run, stall = 1'b0;
    int mismatches = 0, n_compared = 0, pix = 1, base = 0, nn, nd, k;
    int words, gfall, vfall, derr, shigh, dhigh, dpul, viol, expo, fd, scnt, g100, g199;

    // ==========================================================
    // design and sensor model
    cls_timing_gen i_cls_timing_gen (.clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start_i),
        .mode_single_i(mode_single_i), .shutter_en_i(shutter_en_i), .dump_en_i(dump_en_i),
        .integ_cycles_i(integ_cycles_i), .lines_i(lines_i), .busy_o(busy_o),
        .frame_done_o(frame_done_o), .vertical_phase_one_clock_o(v_o),
        .horizontal_last_gate_clock_o(g_o), .substrate_shutter_o(s_o), .dump_gate_o(d_o),
        .adc_data_i(adc), .pix_valid_o(pix_valid_o), .pix_data_o(pix_data_o),
        .pix_ready_i(pix_ready_i));
    cls_ccd_model i_cls_ccd_model (.clk_i(clk_i), .vertical_phase_one_clock_i(v_o),
        .horizontal_last_gate_clock_i(g_o), .adc_data_o(adc));

    initial begin
        forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
    end

    // expected sample: normal rows sit at 0,3,6.. when dumping
    assign exp_data = {7'(base + (dump_en_i ? 3 * (words / pix) : words / pix) + 1),
        7'(words % pix)};

    // ==========================================================
    // pin monitor, counts edges and pulse widths per frame
    always @(posedge clk_i) begin
        v_q <= v_o;
        g_q <= g_o;
        s_q <= s_o;
        d_q <= d_o;
        if (clr) begin
            {words, gfall, vfall, derr, shigh, dhigh, dpul, viol, fd, scnt} = '0;
            run = 1'b0;
        end else begin
            gfall += (g_q && !g_o);
            vfall += (v_q && !v_o);
            // dump gate low at vertical rise
            viol += (v_o && !v_q && d_o);
            shigh += s_o;
            dhigh += d_o;
            dpul += (d_o && !d_q);
            fd += frame_done_o;
            if (run) expo++;
            if (run && v_q && !v_o) run = 1'b0;
            if (s_q && !s_o) begin
                run = 1'b1;
                expo = 0;
            end
            if (pix_valid_o && pix_ready_i) begin
                // samples in pixel and row order
                if (pix_data_o !== exp_data) derr++;
                words++;
            end
            if (stall && pix_valid_o) scnt++;
            if (scnt == 100) g100 = gfall;
            if (scnt == 199) g199 = gfall;
        end
        #1 pix_ready_i = !(stall && scnt < 200);
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results

    initial begin
        #(CLK_PERIOD_NS * 100000);
        mismatches++;
        results();
    end

    // ==========================================================
    // main sequence
    initial begin
        rows[0] = '{1'b0, 1'b1, 1'b0, 24'h00000A, 16'h0001, 1'b1};
        rows[1] = '{1'b1, 1'b0, 1'b0, 24'h000005, 16'h0001, 1'b0};
        rows[2] = '{1'b0, 1'b0, 1'b1, 24'h000000, 16'h0004, 1'b0};
        cyc(20);
        `CHK("reset outs", 7'h00, {busy_o, frame_done_o, v_o, g_o, s_o, d_o, pix_valid_o})
        reset_n_i = 1'b1;
        cyc(1);
        `CHK("release outs", 7'h00, {busy_o, frame_done_o, v_o, g_o, s_o, d_o, pix_valid_o})
        foreach (rows[i]) begin
            clr = 1'b1;
            {mode_single_i, shutter_en_i, dump_en_i} = {rows[i].sgl, rows[i].sht, rows[i].dmp};
            integ_cycles_i = rows[i].integ;
            lines_i = rows[i].lines;
            stall = rows[i].stall;
            pix = rows[i].sgl ? int'(PIX_MIN_SINGLE) : int'(PIX_MIN_DUAL);
            nd = 0;
            for (int r = 0; r < rows[i].lines; r++) nd += (rows[i].dmp && r % 3 != 0);
            nn = rows[i].lines - nd;
            cyc(2);
            clr = 1'b0;
            start_i = 1'b1;
            cyc(1);
            start_i = 1'b0;
            cyc(500);
            // second start while busy must be ignored
            start_i = 1'b1;
            cyc(1);
            start_i = 1'b0;
            k = 0;
            while (frame_done_o !== 1'b1 && k < 60000) begin
                cyc(1);
                k++;
            end
            cyc(3);
            `CHK("words", nn * pix, words)
            `CHK("gate falls", pix * rows[i].lines, gfall)
            `CHK("vert falls", int'(rows[i].lines), vfall)
            `CHK("data errs", 0, derr)
            `CHK("shutter high", rows[i].sht ? int'(T_SUB_CYC) : 0, shigh)
            if (rows[i].sht) `CHK("exposure", rows[i].integ + EXPO_EXTRA_CYC, 24'(expo))
            `CHK("dump pulses", nd, dpul)
            `CHK("dump high", nd * int'(T_FDG_CYC), dhigh)
            `CHK("dump overlap", 0, viol)
            `CHK("done pulses", 1, fd)
            if (rows[i].stall) `CHK("stalled gate", g100, g199)
            `CHK("idle busy", 1'b0, busy_o)
            base += rows[i].lines;
        end
        // reset in mid-frame stops everything
        stall = 1'b0;
        start_i = 1'b1;
        cyc(1);
        start_i = 1'b0;
        cyc(300);
        reset_n_i = 1'b0;
        cyc(2);
        `CHK("mid reset outs", 7'h00, {busy_o, frame_done_o, v_o, g_o, s_o, d_o, pix_valid_o})
        reset_n_i = 1'b1;
        cyc(1000);
        `CHK("after reset busy", 1'b0, busy_o)
        results();
    end
endmodule : tb

// ==== logic/cls_fifo.sv ====
// small first-in first-out buffer with registered read data
`timescale 1ns/1ps
module cls_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_wr;
    logic do_ld;

    // ==========================================================
    // handshakes
    assign in_ready_o = (count != FULL_CNT);
    assign do_wr = in_valid_i && in_ready_o;
    // refill the output register when it is empty or being taken
    assign do_ld = (count != '0) && (!out_valid_o || out_ready_i);

    // storage write, no reset needed on data
    always_ff @(posedge clk_i) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // pointers and fill count; depth is a power of two so pointers wrap
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_ld) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr && !do_ld) begin
                count <= count + 1'b1;
            end else if (!do_wr && do_ld) begin
                count <= count - 1'b1;
            end
        end
    end

    // registered read data
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end else if (do_ld) begin
            out_valid_o <= 1'b1;
            out_data_o <= mem[rd_ptr];
        end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
        end
    end

endmodule : cls_fifo

// ==== logic/cls_pkg.sv ====
// constants and types shared by the ccd line, shutter and dump timing generator
package cls_pkg;

    // ==========================================================
    // clock
    localparam int CLK_PERIOD_NS = 8;

    // ==========================================================
    // pin timing in ns; cycle counts round up so no least time is cut short
    localparam int T_SUB_NS = 1000; // substrate shutter pulse width
    localparam int T_FDG_NS = 2000; // dump gate pulse width
    localparam int T_HD_NS = 1000; // vertical fall to first pixel delay
    localparam int T_VERT_NS = 1000; // vertical phase one high time
    localparam logic [23:0] T_SUB_CYC = 24'((T_SUB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [23:0] T_FDG_CYC = 24'((T_FDG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [23:0] T_HD_CYC = 24'((T_HD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [23:0] T_VERT_CYC = 24'((T_VERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // cycles from substrate fall to vertical fall beyond the programmed count
    localparam logic [23:0] EXPO_EXTRA_CYC = T_VERT_CYC + 24'h000003;

    // ==========================================================
    // horizontal clocking
    localparam logic [12:0] PIX_MIN_DUAL = 13'h09BC;   // pixel counts per row, fast mode
    localparam logic [12:0] PIX_MIN_SINGLE = 13'h1378; // pixel counts per row, slow mode
    localparam logic [1:0] PH_FALL = 2'h1;  // last phase with the last gate high
    localparam logic [1:0] PH_SAMPLE = 2'h2; // first phase after the falling edge
    localparam logic [1:0] PH_END = 2'h3;
    localparam logic [1:0] DUMP_NORMAL = 2'h2; // dump slot that is read out

    // ==========================================================
    // data path
    localparam int ADC_WIDTH = 14;
    localparam int FIFO_DEPTH = 8;

    // ==========================================================
    // sequencer states
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_SHUT = 7'h02,
        ST_INTEG = 7'h04,
        ST_ROW = 7'h08,
        ST_DUMP = 7'h10,
        ST_XFER = 7'h20,
        ST_HDLY = 7'h40
    } cls_state_type;
    localparam logic [6:0] ST_LINE_CODE = 7'h00; // unused marker, line tracked by flag

endpackage : cls_pkg

// ==== logic/cls_timing_gen.sv ====
// timing generator driving the ccd clock pins and buffering read-out samples
// ==========================================================
// Operation
// RULE1 - pixel moves on last-gate clock falling edge
// RULE2 - each row clocks at least 2492/4984 pixels
// RULE3 - substrate shutter pulse optional, else idle
// RULE4 - exposure from substrate fall to vertical fall
// RULE5 - optional dump gate: two dumped, one read
// RULE6 - dump gate finishes before vertical edges
// RULE7 - row moves on vertical phase one fall
// RULE8 - samples from dumped rows never stored
`timescale 1ns/1ps
module cls_timing_gen
    import cls_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // frame control
    input wire logic start_i,
    input wire logic mode_single_i,
    input wire logic shutter_en_i,
    input wire logic dump_en_i,
    input wire logic [23:0] integ_cycles_i,
    input wire logic [15:0] lines_i,
    output logic busy_o,
    output logic frame_done_o,
    // sensor clock pins
    output logic vertical_phase_one_clock_o,
    output logic horizontal_last_gate_clock_o,
    output logic substrate_shutter_o,
    output logic dump_gate_o,
    // converter samples
    input wire logic [ADC_WIDTH-1:0] adc_data_i,
    // pixel stream out
    output logic pix_valid_o,
    output logic [ADC_WIDTH-1:0] pix_data_o,
    input wire logic pix_ready_i
);
    cls_state_type state;
    logic [23:0] cnt;
    logic [15:0] line_cnt;
    logic [15:0] lines_q;
    logic [23:0] integ_q;
    logic [1:0] dump_phase;
    logic mode_q;
    logic shut_q;
    logic dump_en_q;
    logic line_normal;
    logic in_line;
    logic [1:0] phase;
    logic [12:0] pix_cnt;
    logic push;
    logic fifo_ready;
    logic stall;
    logic last_pix;
    logic line_done;

    // pixel count per row for the latched mode
    function automatic logic [12:0] pix_target(input logic single);
        pix_target = single ? PIX_MIN_SINGLE : PIX_MIN_DUAL;
    endfunction : pix_target

    // ==========================================================
    // line level decode
    assign last_pix = (pix_cnt == pix_target(mode_q) - 13'h0001);
    assign push = in_line && line_normal && (phase == PH_SAMPLE);
    // hold the pixel clock rather than drop a sample
    assign stall = push && !fifo_ready;
    assign line_done = in_line && (phase == PH_END) && last_pix;

    // ==========================================================
    // frame sequencer: shutter, integration, dump, vertical transfer
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state <= ST_IDLE;
            cnt <= '0;
            line_cnt <= '0;
            lines_q <= '0;
            integ_q <= '0;
            dump_phase <= DUMP_NORMAL;
            mode_q <= 1'b0;
            shut_q <= 1'b0;
            dump_en_q <= 1'b0;
            line_normal <= 1'b1;
            in_line <= 1'b0;
            busy_o <= 1'b0;
            frame_done_o <= 1'b0;
            vertical_phase_one_clock_o <= 1'b0;
            substrate_shutter_o <= 1'b0;
            dump_gate_o <= 1'b0;
        end else begin
            frame_done_o <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start_i && !in_line) begin
                        // settings latched so a frame stays consistent
                        mode_q <= mode_single_i;
                        shut_q <= shutter_en_i;
                        dump_en_q <= dump_en_i;
                        lines_q <= lines_i;
                        integ_q <= integ_cycles_i;
                        line_cnt <= '0;
                        // first row read normally so exposure ends on a read row
                        dump_phase <= DUMP_NORMAL;
                        busy_o <= 1'b1;
                        // RULE3 optional shutter pulse
                        if (shutter_en_i) begin
                            substrate_shutter_o <= 1'b1;
                            cnt <= T_SUB_CYC - 24'h000001;
                            state <= ST_SHUT;
                        end else begin
                            state <= ST_ROW;
                        end
                    end
                end
                ST_SHUT: begin
                    if (cnt == '0) begin
                        // RULE4 exposure starts here
                        substrate_shutter_o <= 1'b0;
                        cnt <= integ_q;
                        state <= ST_INTEG;
                    end else begin
                        cnt <= cnt - 24'h000001;
                    end
                end
                ST_INTEG: begin
                    if (cnt == '0) begin
                        state <= ST_ROW;
                    end else begin
                        cnt <= cnt - 24'h000001;
                    end
                end
                ST_ROW: begin
                    // RULE5 two dumped rows then one read
                    if (dump_en_q && dump_phase != DUMP_NORMAL) begin
                        line_normal <= 1'b0;
                        dump_gate_o <= 1'b1;
                        cnt <= T_FDG_CYC - 24'h000001;
                        state <= ST_DUMP;
                    end else begin
                        line_normal <= 1'b1;
                        cnt <= T_VERT_CYC;
                        state <= ST_XFER;
                    end
                end
                ST_DUMP: begin
                    if (cnt == '0) begin
                        // RULE6 gate drops before vertical rises
                        dump_gate_o <= 1'b0;
                        cnt <= T_VERT_CYC;
                        state <= ST_XFER;
                    end else begin
                        cnt <= cnt - 24'h000001;
                    end
                end
                ST_XFER: begin
                    // RULE7 row moves on this falling edge
                    if (cnt == '0) begin
                        vertical_phase_one_clock_o <= 1'b0;
                        cnt <= T_HD_CYC - 24'h000001;
                        state <= ST_HDLY;
                    end else begin
                        vertical_phase_one_clock_o <= 1'b1;
                        cnt <= cnt - 24'h000001;
                    end
                end
                ST_HDLY: begin
                    if (cnt == '0) begin
                        in_line <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt - 24'h000001;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
            // row finished: next row or end of frame
            if (line_done) begin
                in_line <= 1'b0;
                dump_phase <= (dump_phase == DUMP_NORMAL) ? 2'h0 : dump_phase + 2'h1;
                line_cnt <= line_cnt + 16'h0001;
                if (line_cnt + 16'h0001 >= lines_q) begin
                    busy_o <= 1'b0;
                    frame_done_o <= 1'b1;
                end else begin
                    state <= ST_ROW;
                end
            end
        end
    end

    // ==========================================================
    // horizontal clocking, four clocks per pixel
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            phase <= '0;
            pix_cnt <= '0;
            horizontal_last_gate_clock_o <= 1'b0;
        end else if (state == ST_HDLY && cnt == '0) begin
            phase <= '0;
            pix_cnt <= '0;
            horizontal_last_gate_clock_o <= 1'b1;
        end else if (in_line && !stall) begin
            phase <= phase + 2'h1;
            // RULE1 last gate falls after phase one
            horizontal_last_gate_clock_o <= (phase == PH_END && !last_pix) || (phase == 2'h0);
            // RULE2 full pixel count each row
            if (phase == PH_END) begin
                pix_cnt <= pix_cnt + 13'h0001;
            end
        end
    end

    // ==========================================================
    // sample buffer; a full buffer stalls the horizontal clock
    cls_fifo #(
        .WIDTH(ADC_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(push),
        .in_data_i(adc_data_i),
        .in_ready_o(fifo_ready),
        .out_valid_o(pix_valid_o),
        .out_data_o(pix_data_o),
        .out_ready_i(pix_ready_i)
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    logic [23:0] expo_cnt;
    logic expo_run;
    // exposure length helper
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            expo_cnt <= '0;
            expo_run <= 1'b0;
        end else if (state == ST_SHUT && cnt == '0) begin
            expo_cnt <= '0;
            expo_run <= 1'b1;
        end else if (expo_run) begin
            expo_cnt <= expo_cnt + 24'h000001;
            if (!vertical_phase_one_clock_o && $past(vertical_phase_one_clock_o)) begin
                expo_run <= 1'b0;
            end
        end
    end

    logic [12:0] row_falls, row_writes;
    // per-row gate falls from the pin and buffer writes from push and fifo_ready; a stalled sample counts once
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || (state == ST_HDLY && cnt == '0)) begin
            row_falls <= '0;
            row_writes <= '0;
        end else begin
            if (!horizontal_last_gate_clock_o && $past(horizontal_last_gate_clock_o)) begin
                row_falls <= row_falls + 13'h0001;
            end
            if (push && fifo_ready) begin
                row_writes <= row_writes + 13'h0001;
            end
        end
    end

    // RULE1 sample follows fall
    last_gate_fall_a: assert property ((push && $past(phase) == PH_FALL) // RULE1
        |-> $fell(horizontal_last_gate_clock_o)) else $error("sample without gate fall");
    // RULE2 pixel count
    row_pixels_a: assert property (line_done |-> // RULE2
        row_falls == (mode_q ? PIX_MIN_SINGLE : PIX_MIN_DUAL)) else $error("row pixels wrong");
    // RULE3 shutter only when enabled
    shutter_gate_a: assert property (substrate_shutter_o |-> shut_q && state == ST_SHUT) // RULE3
        else $error("substrate pulsed while disabled");
    // RULE4 exposure length
    expo_length_a: assert property ((expo_run && $fell(vertical_phase_one_clock_o)) // RULE4
        |-> expo_cnt == integ_q + EXPO_EXTRA_CYC) else $error("exposure length wrong");
    // RULE5 dump only when enabled
    dump_enable_a: assert property ($rose(dump_gate_o) |-> dump_en_q && !line_normal) // RULE5
        else $error("dump gate without enable");
    // RULE6 dump gate done before vertical
    dump_order_a: assert property ($rose(vertical_phase_one_clock_o) |-> !dump_gate_o // RULE6
        && !$past(dump_gate_o)) else $error("dump gate overlaps vertical");
    // RULE7 horizontal waits for vertical fall
    line_start_a: assert property ($fell(vertical_phase_one_clock_o) // RULE7
        |-> state == ST_HDLY && cnt == T_HD_CYC - 24'h000001 && !in_line)
        else $error("row transfer out of order");
    // RULE8 dumped rows stay out of the buffer
    dump_drop_a: assert property (line_done |-> row_writes == // RULE8
        (line_normal ? pix_target(mode_q) : 13'h0000)) else $error("dumped sample stored");

endmodule : cls_timing_gen
